/* File: test/lld_asserts.sv */
module lld_asserts (
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    // memory pins
    input wire logic command_clock,
    input wire logic mem_select_n,
    input wire logic mem_write_n,
    input wire logic mem_refresh_n,
    input wire logic [20:0] address_pins,
    input wire logic [2:0] bank_select,
    input wire logic write_byte_mask,
    input wire logic dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // strobe code, all low is a mode load
    wire [2:0] pins = {mem_select_n, mem_write_n, mem_refresh_n};
    wire mode_ld = pins == 3'h0;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // pins against the divided clock
    a_ck_period: assert property ($rose(command_clock) && $past(hresetn, 2)
        |-> ##8 $fell(command_clock) ##8 $rose(command_clock)) else $error("bad period");
    a_cmd_at_fall: assert property ($changed({pins, bank_select}) |-> $fell(command_clock))
        else $error("pins off fall");
    a_cmd_stands: assert property ($fell(mem_select_n) |-> !mem_select_n [*8] ##9 mem_select_n)
        else $error("bad length");
    a_mode_high_zero: assert property (mode_ld |-> address_pins[17:10] == 8'h00)
        else $error("reserved bits set");
    a_no_bl8: assert property (mode_ld && address_pins[4:3] == 2'h2
        |-> !(address_pins[2:0] inside {3'h0, 3'h1, 3'h4})) else $error("bl8 not allowed");
    a_refresh_gap: assert property ($fell(mem_refresh_n) |-> ##16 mem_select_n [*8])
        else $error("row cycle short");
    a_mask_idle: assert property (dq_oe_n |-> !write_byte_mask)
        else $error("stray mask");
    a_one_wait: assert property (!hreadyout |=> hreadyout)
        else $error("long wait");
    // main traffic seen
    c_write: cover property ($fell(dq_oe_n));
    c_refresh: cover property ($fell(mem_refresh_n));
    c_mode: cover property (mode_ld);
endmodule : lld_asserts

/* File: test/lld_mem_model.sv */
module lld_mem_model (
    // command side
    input wire logic ck,
    input wire logic dk,
    input wire logic sel_n,
    input wire logic we_n,
    input wire logic ref_n,
    input wire logic [20:0] a,
    // data side
    input wire logic dm,
    input wire logic [17:0] d,
    output logic [17:0] q,
    output logic qk0,
    output logic qk1,
    output logic vld
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] mem [64];
    logic [9:0] mode = 10'h000;
    int lt [8] = '{4, 4, 6, 8, 3, 5, 4, 4};
    // read clocks run free, so data edges line up with them
    assign qk0 = ck;
    assign qk1 = ck;
    initial begin
        foreach (mem[i]) mem[i] = 18'(i);
        q = 18'h0;
        vld = 1'b0;
    end
    // a thread per read or write, mode loads at once; refresh needs nothing, rows come from inside
    always @(posedge ck) begin
        if (pins_mode()) mode = a[9:0];
        else if (!sel_n && !we_n) fork wr(a[5:0], lt[mode[2:0]] + 1); join_none
        else if (!sel_n && ref_n) fork rd(a[5:0], lt[mode[2:0]]); join_none
    end
    function automatic logic pins_mode;
        return !sel_n && !we_n && !ref_n;
    endfunction : pins_mode
    // wait for the fall first: dk and ck move in the same step
    task automatic wr(input logic [5:0] ad, input int lat);
        @(negedge ck);
        repeat (lat) @(posedge dk);
        for (int i = 0; i < (2 << mode[4:3]); i++) begin
            if (i % 2 == 1) @(negedge dk);
            else if (i > 0) @(posedge dk);
            if (!dm) mem[ad + 6'(i)] = d;
        end
    endtask : wr
    // flag half a clock ahead, then one beat per edge
    task automatic rd(input logic [5:0] ad, input int lat);
        repeat (lat - 1) @(posedge ck);
        @(negedge ck) vld = 1'b1;
        for (int i = 0; i < (2 << mode[4:3]); i++) begin
            if (i % 2 == 1) @(negedge ck);
            else @(posedge ck);
            q = mem[ad + 6'(i)];
        end
        vld = 1'b0;
        @(posedge ck);
        if (!vld) q = ~q;
    endtask : rd
endmodule : lld_mem_model

/* File: test/test_lld_ctrl.sv */
module test_lld_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, junk;
    logic hreadyout, hresp, command_clock, command_clock_n, mem_select_n, mem_write_n, mem_refresh_n;
    logic write_data_clock, write_data_clock_n, write_byte_mask, dq_oe_n, lower_read_clock, upper_read_clock;
    logic read_valid_flag;
    logic [20:0] address_pins;
    logic [17:0] dq_out, dq_in, mq;
    int num_errors = 0, compares = 0, cyc = 0;
    // shared data wire: the controller wins only while its enable is low
    assign dq_in = dq_oe_n ? mq : dq_out;
    initial forever #5 hclk = ~hclk;
    lld_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .command_clock, .command_clock_n, .mem_select_n, .mem_write_n,
        .mem_refresh_n, .address_pins, .bank_select(), .write_data_clock, .write_data_clock_n,
        .write_byte_mask, .dq_out, .dq_oe_n, .dq_in, .lower_read_clock, .upper_read_clock, .read_valid_flag);
    lld_mem_model mdl (.ck(command_clock), .dk(write_data_clock), .sel_n(mem_select_n), .we_n(mem_write_n),
        .ref_n(mem_refresh_n), .a(address_pins), .dm(write_byte_mask), .d(dq_in), .q(mq),
        .qk0(lower_read_clock), .qk1(upper_read_clock), .vld(read_valid_flag));
    // one transfer: address held until ready, data taken on the second ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, junk);
    endtask : wr
    task automatic ck_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        compares++;
        if ((q & m) !== e) begin
            num_errors++;
            $display("BAD %0t reg %h got %h", $time, a, q);
        end
    endtask : ck_reg
    // poll status until the sequencer is idle
    task automatic idle;
        logic [31:0] q;
        q = 32'h1;
        while (q[0] !== 1'b0) bus(1'b0, 8'h08, 32'h0, q);
    endtask : idle
    // reset value, then a burst-of-eight load in config one is refused
    task automatic t_bad_mode;
        ck_reg(8'h00, 32'h001, 32'h3FF);
        wr(8'h00, 32'h091);
        wr(8'h04, 32'h003);
        idle();
        ck_reg(8'h08, 32'h002, 32'h002);
        wr(8'h08, 32'h002);
        ck_reg(8'h08, 32'h000, 32'h002);
    endtask : t_bad_mode
    // config two load, refresh left running
    task automatic t_mode;
        wr(8'h00, 32'h082);
        wr(8'h04, 32'h003);
        idle();
        ck_reg(8'h08, 32'h020, 32'h1F0);
    endtask : t_mode
    // write with beat one masked, then read straight back
    task automatic t_data;
        wr(8'h20, 32'h12345);
        wr(8'h24, 32'h3ABCD);
        wr(8'h0C, 32'h002);
        wr(8'h04, 32'h08D);
        idle();
        wr(8'h04, 32'h08C);
        idle();
        ck_reg(8'h40, 32'h12345, 32'h3FFFF);
        ck_reg(8'h44, 32'h00005, 32'h3FFFF);
    endtask : t_data
    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_bad_mode();
        t_mode();
        t_data();
        stop_test();
    end
    // hang guard, far beyond the few hundred cycles each command takes
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            stop_test();
        end
    end
endmodule : test_lld_ctrl
bind lld_ctrl lld_asserts chk (.hclk, .hresetn, .hreadyout, .command_clock, .mem_select_n, .mem_write_n,
    .mem_refresh_n, .address_pins, .bank_select, .write_byte_mask, .dq_oe_n);

/* File: verilog/lld_ahb_slave.sv */
module lld_ahb_slave (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // register side
    lld_reg_if.slave rb
);
    typedef struct packed {
        logic pend;
        logic pwrite;
        logic [7:0] paddr;
        logic ready;
        logic [31:0] rdata;
        logic resp;
    } lld_ahb_t;
    lld_ahb_t r;
    lld_ahb_t nx;

    // one wait state so read data can come from a flop
    always_comb begin
        nx = r;
        nx.resp = 1'b0;
        if (r.pend) begin
            nx.pend = 1'b0;
            nx.ready = 1'b1;
            if (!r.pwrite) begin
                nx.rdata = rb.rdata;
            end
        end else if (hsel && htrans[1] && hready && hsize == 3'h2) begin
            nx.pend = 1'b1;
            nx.ready = 1'b0;
            nx.pwrite = hwrite;
            nx.paddr = haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.ready <= 1'b1;
        end else begin
            r <= nx;
        end
    end

    // strobes last the single wait cycle, when hwdata stands
    assign rb.wr = r.pend && r.pwrite;
    assign rb.rd = r.pend && !r.pwrite;
    assign rb.addr = r.paddr;
    assign rb.wdata = hwdata;
    assign hreadyout = r.ready;
    assign hrdata = r.rdata;
    assign hresp = r.resp;
endmodule : lld_ahb_slave

/* File: verilog/lld_ctrl.sv */
module lld_ctrl (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // command and address pins
    output logic command_clock,
    output logic command_clock_n,
    output logic mem_select_n,
    output logic mem_write_n,
    output logic mem_refresh_n,
    output logic [20:0] address_pins,
    output logic [2:0] bank_select,
    // write data pins
    output logic write_data_clock,
    output logic write_data_clock_n,
    output logic write_byte_mask,
    output logic [17:0] dq_out,
    output logic dq_oe_n,
    // read data pins
    input wire logic [17:0] dq_in,
    input wire logic lower_read_clock,
    input wire logic upper_read_clock,
    input wire logic read_valid_flag
);
    typedef enum logic [2:0] {S_IDLE, S_CMD, S_ADDR2, S_DATA, S_GAP} lld_state_t;

    typedef struct packed {
        lld_pkg::lld_ctrl_t ctrl;
        logic [7:0] mask;
        logic [7:0][17:0] wbuf;
        logic [7:0][17:0] rbuf;
        lld_pkg::lld_cmd_t cmd;
        logic cmd_pend;
        logic err;
        lld_state_t st;
        logic [1:0] op;
        logic [3:0] ph;
        logic [4:0] cc;
        logic [3:0] bi;
        logic wact;
        logic [2:0] mcfg;
        logic [1:0] mbl;
        logic mmux;
        logic [7:0] rtmr;
        logic ref_pend;
        logic [2:0] ref_bank;
        logic [20:0] ay;
        logic ck;
        logic ckn;
        logic [2:0] pcmd;
        logic [20:0] a;
        logic [2:0] ba;
        logic [17:0] dq;
        logic oe_n;
        logic dm;
    } lld_core_t;

    lld_core_t r;
    lld_core_t nx;
    lld_reg_if rb ();
    lld_rd_if rdq ();

    logic busy;
    logic rise;
    logic fall;
    logic mid;
    logic [3:0] rl;
    logic [4:0] rl_eff;
    logic [4:0] wl_eff;
    logic [4:0] gap_len;
    logic [3:0] beats;

    lld_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rb(rb)
    );

    lld_rd_sampler u_sampler (
        .hclk(hclk),
        .hresetn(hresetn),
        .lower_read_clock(lower_read_clock),
        .upper_read_clock(upper_read_clock),
        .read_valid_flag(read_valid_flag),
        .dq_in(dq_in),
        .rd(rdq)
    );

    // second address half; the fixed map assumes the 18-bit part
    function automatic logic [20:0] second_half(input logic [20:0] w);
        logic [20:0] m;
        m = 21'h000000;
        m[0] = w[20];
        m[3] = w[1];
        m[4] = w[2];
        m[8] = w[6];
        m[9] = w[7];
        m[10] = w[19];
        m[13] = w[11];
        m[14] = w[12];
        m[17] = w[16];
        m[18] = w[15];
        return m;
    endfunction : second_half

    // combinations the memory cannot run are refused at the register write
    function automatic logic bad_mode(input lld_pkg::lld_ctrl_t c);
        logic cfg14;
        cfg14 = c.cfg == 3'h0 || c.cfg == lld_pkg::CFG_ONE || c.cfg == lld_pkg::CFG_FOUR;
        return c.bl == lld_pkg::BL_BAD || c.cfg > lld_pkg::CFG_MAX
            || (c.bl == lld_pkg::BL_EIGHT && (cfg14 || c.mux));
    endfunction : bad_mode

    // latencies follow the last loaded mode, not the control register
    assign rl = lld_pkg::LAT_TABLE[r.mcfg];
    assign rl_eff = {1'b0, rl} + {4'h0, r.mmux};
    assign wl_eff = rl_eff + 5'h01;
    assign gap_len = {1'b0, rl} + {4'h0, r.mcfg == lld_pkg::CFG_FOUR && r.op == lld_pkg::OP_WRITE};
    assign beats = 4'h2 << r.mbl;
    assign busy = r.cmd_pend || r.st != S_IDLE;
    assign rise = r.ph == lld_pkg::PH_LAST;
    assign fall = r.ph == lld_pkg::PH_FALL;
    assign mid = r.ph == lld_pkg::PH_MID_HI || r.ph == lld_pkg::PH_MID_LO;

    // register read mux, unmapped words read zero
    always_comb begin
        rb.rdata = 32'h00000000;
        case (rb.addr)
            lld_pkg::OFS_CTRL: begin
                rb.rdata = 32'(r.ctrl);
            end
            lld_pkg::OFS_CMD: begin
                rb.rdata = 32'(r.cmd);
            end
            lld_pkg::OFS_STATUS: begin
                rb.rdata = 32'({r.mbl, r.mcfg, r.mmux, r.ref_pend, r.err, busy});
            end
            lld_pkg::OFS_MASK: begin
                rb.rdata = 32'(r.mask);
            end
            default: begin
                if (rb.addr[7:5] == lld_pkg::PAGE_WBUF) begin
                    rb.rdata = 32'(r.wbuf[rb.addr[4:2]]);
                end else if (rb.addr[7:5] == lld_pkg::PAGE_RBUF) begin
                    rb.rdata = 32'(r.rbuf[rb.addr[4:2]]);
                end
            end
        endcase
    end

    // core: divider, register writes, command sequencer, data path
    always_comb begin
        logic go;
        logic [1:0] lop;
        logic [2:0] lbank;
        logic [20:0] word;
        go = 1'b0;
        lop = lld_pkg::OP_READ;
        lbank = 3'h0;
        word = 21'h000000;
        nx = r;
        // command clock by divider; write data clock runs in phase with it
        nx.ph = rise ? 4'h0 : r.ph + 4'h1;
        nx.ck = nx.ph <= lld_pkg::PH_FALL;
        nx.ckn = !nx.ck;
        if (rise && r.st != S_IDLE && r.cc != 5'h1F) begin
            nx.cc = r.cc + 5'h01;
        end
        // register writes; error clear comes first so later sets win
        if (rb.wr) begin
            case (rb.addr)
                lld_pkg::OFS_CTRL: begin
                    nx.ctrl = rb.wdata[$bits(lld_pkg::lld_ctrl_t) - 1:0];
                end
                lld_pkg::OFS_CMD: begin
                    if (r.cmd_pend || (rb.wdata[1:0] == lld_pkg::OP_MODE && bad_mode(r.ctrl))) begin
                        nx.err = 1'b1;
                    end else begin
                        nx.cmd = rb.wdata[$bits(lld_pkg::lld_cmd_t) - 1:0];
                        nx.cmd_pend = 1'b1;
                    end
                end
                lld_pkg::OFS_STATUS: begin
                    if (rb.wdata[lld_pkg::STAT_ERR_BIT]) begin
                        nx.err = 1'b0;
                    end
                end
                lld_pkg::OFS_MASK: begin
                    nx.mask = rb.wdata[7:0];
                end
                default: begin
                    if (rb.addr[7:5] == lld_pkg::PAGE_WBUF) begin
                        nx.wbuf[rb.addr[4:2]] = rb.wdata[17:0];
                    end
                end
            endcase
        end
        // sequencer; commands change on the falling edge, stable at the rise
        case (r.st)
            S_IDLE: begin
                if (fall && r.ref_pend && r.ctrl.ref_en) begin
                    go = 1'b1;
                    lop = lld_pkg::OP_REFRESH;
                    lbank = r.ref_bank;
                    nx.ref_bank = r.ref_bank + 3'h1;
                    nx.ref_pend = r.ref_bank != 3'h7;
                end else if (fall && r.cmd_pend) begin
                    go = 1'b1;
                    lop = r.cmd.op;
                    lbank = r.cmd.bank;
                    nx.cmd_pend = 1'b0;
                end
            end
            S_CMD: begin
                if (fall) begin
                    nx.pcmd = lld_pkg::PIN_NOP;
                    if (r.mmux && r.op != lld_pkg::OP_REFRESH) begin
                        nx.a = r.ay;
                        nx.st = S_ADDR2;
                    end else begin
                        nx.a = 21'h000000;
                        nx.st = r.op[1] ? S_GAP : S_DATA;
                    end
                end
            end
            S_ADDR2: begin
                if (fall) begin
                    nx.a = 21'h000000;
                    nx.st = r.op[1] ? S_GAP : S_DATA;
                end
            end
            S_DATA: begin
                // a read is done after burst-length beats from the sampler
                if (r.op == lld_pkg::OP_READ && rdq.beat) begin
                    nx.rbuf[r.bi[2:0]] = rdq.data;
                    nx.bi = r.bi + 4'h1;
                    if (r.bi + 4'h1 == beats) begin
                        nx.st = S_GAP;
                        nx.cc = 5'h00;
                    end
                end else if (r.op == lld_pkg::OP_READ && rise && r.cc == rl_eff + lld_pkg::RD_TMO_CK) begin
                    // no answer: flag it rather than hang the sequencer
                    nx.err = 1'b1;
                    nx.st = S_GAP;
                    nx.cc = 5'h00;
                end
            end
            S_GAP: begin
                // whole row cycle before the next command, any bank
                if (rise && r.cc >= gap_len) begin
                    nx.st = S_IDLE;
                end
            end
            default: begin
                nx.st = S_IDLE;
            end
        endcase
        // launch: bank always with the command, address per mode
        if (go) begin
            case (lop)
                lld_pkg::OP_READ: begin
                    nx.pcmd = lld_pkg::PIN_READ;
                    word = r.cmd.addr;
                end
                lld_pkg::OP_WRITE: begin
                    nx.pcmd = lld_pkg::PIN_WRITE;
                    word = r.cmd.addr;
                end
                lld_pkg::OP_REFRESH: begin
                    nx.pcmd = lld_pkg::PIN_REFRESH;
                end
                default: begin
                    nx.pcmd = lld_pkg::PIN_MODE;
                    word[2:0] = r.ctrl.cfg;
                    word[lld_pkg::MODE_BL_LSB +: 2] = r.ctrl.bl;
                    word[lld_pkg::MODE_MUX_BIT] = r.ctrl.mux;
                    word[lld_pkg::MODE_PLL_BIT] = r.ctrl.pll_on;
                    word[lld_pkg::MODE_IMP_BIT] = r.ctrl.imp_ext;
                    word[lld_pkg::MODE_ODT_BIT] = r.ctrl.on_die_termination;
                    nx.mcfg = r.ctrl.cfg;
                    nx.mbl = r.ctrl.bl;
                    nx.mmux = r.ctrl.mux;
                end
            endcase
            nx.op = lop;
            nx.ba = lbank;
            nx.a = r.mmux && lop != lld_pkg::OP_REFRESH ? word & lld_pkg::MUX_PINS : word;
            nx.ay = second_half(word);
            nx.cc = 5'h00;
            nx.bi = 4'h0;
            nx.st = S_CMD;
        end
        // write beats change mid half-cycle, centred on both clock edges
        if (mid && r.wact) begin
            if (r.bi == beats) begin
                nx.wact = 1'b0;
                nx.oe_n = 1'b1;
                nx.dm = 1'b0;
                nx.st = S_GAP;
                nx.cc = 5'h00;
            end else begin
                nx.dq = r.wbuf[r.bi[2:0]];
                nx.dm = r.mask[r.bi[2:0]];
                nx.bi = r.bi + 4'h1;
            end
        end else if (r.ph == lld_pkg::PH_MID_LO && r.op == lld_pkg::OP_WRITE && r.cc == wl_eff
                     && (r.st == S_CMD || r.st == S_ADDR2 || r.st == S_DATA)) begin
            nx.wact = 1'b1;
            nx.oe_n = 1'b0;
            nx.dq = r.wbuf[0];
            nx.dm = r.mask[0];
            nx.bi = 4'h1;
        end
        // refresh round timer; expiry sets the request and wins over its clear
        if (r.rtmr == 8'h00) begin
            nx.rtmr = lld_pkg::REF_RELOAD;
            if (r.ctrl.ref_en) begin
                nx.ref_pend = 1'b1;
            end
        end else begin
            nx.rtmr = r.rtmr - 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.ctrl <= lld_pkg::CTRL_RESET;
            r.mcfg <= lld_pkg::CFG_ONE;
            r.pcmd <= lld_pkg::PIN_NOP;
            r.oe_n <= 1'b1;
            r.ckn <= 1'b1;
            r.rtmr <= lld_pkg::REF_RELOAD;
        end else begin
            r <= nx;
        end
    end

    // pins straight from the core flops
    assign command_clock = r.ck;
    assign command_clock_n = r.ckn;
    assign write_data_clock = r.ck;
    assign write_data_clock_n = r.ckn;
    assign mem_select_n = r.pcmd[2];
    assign mem_write_n = r.pcmd[1];
    assign mem_refresh_n = r.pcmd[0];
    assign address_pins = r.a;
    assign bank_select = r.ba;
    assign dq_out = r.dq;
    assign dq_oe_n = r.oe_n;
    assign write_byte_mask = r.dm;
endmodule : lld_ctrl

/* File: verilog/lld_if.sv */
// register access from the bus slave to the controller core
interface lld_reg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr, rd, addr, wdata, input rdata);
    modport regs (input wr, rd, addr, wdata, output rdata);
endinterface : lld_reg_if

// read beats from the sampler to the controller core
interface lld_rd_if;
    logic beat;
    logic [17:0] data;
    modport src (output beat, data);
    modport dst (input beat, data);
endinterface : lld_rd_if

/* File: verilog/lld_pkg.sv */
// Functional notes
// - configs 1..5 set row cycle and read latency to 4,6,8,3,5 clocks
// - command clock must stay inside the range allowed for the chosen config
// - burst of eight is refused with config one or config four
// - config four: bank reuse after 3 clocks, write then read waits 4
// - non-multiplexed: full row address and bank go with the command
// - write beats taken on both write clock edges, first at latency rise
// - a beat with the byte mask high is discarded by the memory
// - read may follow a write burst and write may follow a read burst
// - after a bank refresh wait one row cycle before using that bank
// - every row of every bank refreshed within each 32 ms
// - mode bit A9 turns on termination of data and mask inputs only
// - multiplexed mode sends the address in two halves on two rises
// - multiplexed mode sends the bank with the command and first half
// - mode bit A5 enters multiplexed mode for read, write and mode load
package lld_pkg;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int LINK_HALF = 8;
    localparam logic [3:0] PH_LAST = 4'(2 * LINK_HALF - 1);
    localparam logic [3:0] PH_FALL = 4'(LINK_HALF - 1);
    localparam logic [3:0] PH_MID_HI = 4'(LINK_HALF / 2 - 1);
    localparam logic [3:0] PH_MID_LO = 4'(LINK_HALF + LINK_HALF / 2 - 1);
    localparam int REF_ROUND_NS = 1950;
    localparam int REF_ROUND_CYC = REF_ROUND_NS * CLK_MHZ / 1000;
    localparam logic [7:0] REF_RELOAD = 8'(REF_ROUND_CYC - 1);
    localparam logic [4:0] RD_TMO_CK = 5'h08;
    // register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [2:0] PAGE_WBUF = 3'h1;
    localparam logic [2:0] PAGE_RBUF = 3'h2;
    localparam int STAT_ERR_BIT = 1;
    // control register, bit 0 upward: cfg, bl, mux, odt, ref_en, imp_ext, pll_on
    typedef struct packed {
        logic pll_on;
        logic imp_ext;
        logic ref_en;
        logic on_die_termination;
        logic mux;
        logic [1:0] bl;
        logic [2:0] cfg;
    } lld_ctrl_t;
    localparam lld_ctrl_t CTRL_RESET = 10'h001;
    typedef struct packed {
        logic [20:0] addr;
        logic [2:0] bank;
        logic [1:0] op;
    } lld_cmd_t;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_REFRESH = 2'h2;
    localparam logic [1:0] OP_MODE = 2'h3;
    localparam logic [1:0] BL_EIGHT = 2'h2;
    localparam logic [1:0] BL_BAD = 2'h3;
    localparam logic [2:0] CFG_ONE = 3'h1;
    localparam logic [2:0] CFG_FOUR = 3'h4;
    localparam logic [2:0] CFG_MAX = 3'h5;
    // pin codes {select_n, write_n, refresh_n}
    localparam logic [2:0] PIN_NOP = 3'h7;
    localparam logic [2:0] PIN_READ = 3'h3;
    localparam logic [2:0] PIN_WRITE = 3'h1;
    localparam logic [2:0] PIN_REFRESH = 3'h2;
    localparam logic [2:0] PIN_MODE = 3'h0;
    // mode word bit positions
    localparam int MODE_BL_LSB = 3;
    localparam int MODE_MUX_BIT = 5;
    localparam int MODE_PLL_BIT = 7;
    localparam int MODE_IMP_BIT = 8;
    localparam int MODE_ODT_BIT = 9;
    // latency per config code, code 0 behaves as config one
    localparam logic [7:0][3:0] LAT_TABLE = 32'h00538644;
    // pins carried by the first half in multiplexed mode
    localparam logic [20:0] MUX_PINS = 21'h066739;
endpackage : lld_pkg

/* File: verilog/lld_rd_sampler.sv */
module lld_rd_sampler (
    // system
    input wire logic hclk,
    input wire logic hresetn,
    // memory read pins
    input wire logic lower_read_clock,
    input wire logic upper_read_clock,
    input wire logic read_valid_flag,
    input wire logic [17:0] dq_in,
    // beats to the core
    lld_rd_if.src rd
);
    typedef struct packed {
        logic [1:0] qk1;
        logic [1:0] qk2;
        logic [1:0] qk3;
        logic v1;
        logic v2;
        logic [1:0] vcnt;
        logic [17:0] d1;
        logic [17:0] d2;
        logic [17:0] hold;
        logic beat;
        logic [17:0] data;
    } lld_smp_t;
    lld_smp_t r;
    lld_smp_t nx;

    // pins pass two flops; data and clocks share the delay, so alignment holds
    always_comb begin
        nx = r;
        nx.qk1 = {upper_read_clock, lower_read_clock};
        nx.qk2 = r.qk1;
        nx.qk3 = r.qk2;
        nx.v1 = read_valid_flag;
        nx.v2 = r.v1;
        nx.d1 = dq_in;
        nx.d2 = r.d1;
        // flag must lead the edge, so an edge in its first cycles is no beat
        if (!r.v2) begin
            nx.vcnt = 2'h0;
        end else if (r.vcnt != 2'h2) begin
            nx.vcnt = r.vcnt + 2'h1;
        end
        // each half is caught on its own read clock edge
        for (int h = 0; h < 2; h++) begin
            if (r.qk2[h] != r.qk3[h]) begin
                nx.hold[h * 9 +: 9] = r.d2[h * 9 +: 9];
            end
        end
        nx.beat = (r.qk2[0] != r.qk3[0]) && r.vcnt == 2'h2;
        nx.data = nx.hold;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else begin
            r <= nx;
        end
    end

    assign rd.beat = r.beat;
    assign rd.data = r.data;
endmodule : lld_rd_sampler
